// *** test/mem_periph_model.sv ***
`timescale 1ns/1ps
module mem_periph_model
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Memory bus side
   input wire dma_pkg::mem_req_t mem_in,
   output logic mem_ack_out,
   output logic mem_err_out,
   output logic [31:0] mem_rdata_out,
   // Peripheral side
   input wire logic [1:0] go_in,
   input wire logic [3:0] slow_in,
   output logic [1:0] periph_req_out,
   output logic [31:0] periph_data_out
);
   logic [3:0] wait_cnt;

   // Memory answers after slow_in idle cycles; top nibble f is invalid
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mem_ack_out <= 1'b0;
         mem_err_out <= 1'b0;
         mem_rdata_out <= 32'h0000_0000;
         wait_cnt <= 4'h0;
         periph_data_out <= 32'h0000_0000;
      end
      else
      begin
         periph_data_out <= periph_data_out + 32'h0101_0101;
         if (mem_in.req && !mem_ack_out && wait_cnt >= slow_in)
         begin
            mem_ack_out <= 1'b1;
            mem_err_out <= (mem_in.addr[31:28] == 4'hf);
            mem_rdata_out <= mem_in.addr ^ 32'h5a5a_0000;
            wait_cnt <= 4'h0;
         end
         else
         begin
            // Released data is inverted each cycle, so a stale value reappears every second cycle
            mem_ack_out <= 1'b0;
            mem_err_out <= 1'b0;
            mem_rdata_out <= ~mem_rdata_out;
            wait_cnt <= mem_in.req ? wait_cnt + 4'h1 : 4'h0;
         end
      end
   end

   // Peripheral keeps asking while told to; the channel must stop on its own
   assign periph_req_out = go_in;
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   logic clk;
   logic rst;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   dma_pkg::mem_req_t mreq;
   logic mack;
   logic merr;
   logic [31:0] mrdata;
   logic [1:0] preq;
   logic [31:0] pdata_in;
   logic [1:0] pack;
   logic [31:0] pdata_out;
   logic [1:0] irq;
   logic [1:0] go;
   logic [3:0] slow;
   int failures;
   int n_compared;
   int seen;
   int n;
   logic [31:0] step;
   logic [31:0] pword;

   peripheral_dma_unit #(.NUM_CH(2), .CH_W(1)) dut (.core_clk_in(clk), .rst_in(rst),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .mem_out(mreq), .mem_ack_in(mack), .mem_err_in(merr), .mem_rdata_in(mrdata),
      .periph_req_in(preq), .periph_data_in(pdata_in), .periph_ack_out(pack),
      .periph_data_out(pdata_out), .irq_out(irq));
   mem_periph_model partner (.core_clk_in(clk), .rst_in(rst), .mem_in(mreq),
      .mem_ack_out(mack), .mem_err_out(merr), .mem_rdata_out(mrdata), .go_in(go),
      .slow_in(slow), .periph_req_out(preq), .periph_data_out(pdata_in));

   // Clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      #400000;
      failures++;
      finish_test();
   end

   task automatic finish_test();
      $display("compared=%0d failures=%0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is sampled high
   task automatic xfer(input logic wr, input logic [5:0] ch, input logic [5:0] ofs,
                       input logic [31:0] d, input logic [31:0] exp, input logic exp_err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {ch, ofs};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // No wait-state limit of its own: only the watchdog ends a hung access
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      if (!wr)
         cmp(prdata, exp);
      cmp({31'h0, pslverr}, {31'h0, exp_err});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr_reg(input logic [5:0] ch, input logic [5:0] ofs, input logic [31:0] d);
      xfer(1'b1, ch, ofs, d, 32'h0, 1'b0);
   endtask

   task automatic rd_reg(input logic [5:0] ch, input logic [5:0] ofs, input logic [31:0] e);
      xfer(1'b0, ch, ofs, 32'h0, e, 1'b0);
   endtask

   task automatic prog(input logic [5:0] ch, input logic [1:0] sz, input logic [31:0] a,
                       input logic [31:0] c, input logic [31:0] ra, input logic [31:0] rc);
      wr_reg(ch, 6'h18, {30'h0, sz});
      wr_reg(ch, 6'h00, a);
      wr_reg(ch, 6'h08, c);
      wr_reg(ch, 6'h0c, ra);
      wr_reg(ch, 6'h10, rc);
   endtask

   // Count item pulses; read data must come from the stepped address
   task automatic wait_acks(input int ch, input int cnt, input logic [31:0] base,
                            input logic [31:0] stp);
      int t;
      seen = 0;
      t = 0;
      while (seen < cnt && t < 2000)
      begin
         @(posedge clk);
         t++;
         if (pack[ch] === 1'b1)
         begin
            cmp(pdata_out, (base + stp * seen) ^ 32'h5a5a_0000);
            seen++;
         end
      end
      cmp(32'(seen), 32'(cnt));
   endtask

   task automatic quiet(input int ch);
      seen = 0;
      repeat (20)
      begin
         @(posedge clk);
         if (pack[ch] !== 1'b0)
            seen++;
      end
   endtask

   initial
   begin
      failures = 0;
      n_compared = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      go = 2'b00;
      slow = 4'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values, unmapped and read-only places
      for (int o = 0; o < 44; o += 4)
         rd_reg(6'h0, 6'(o), 32'h0);
      rd_reg(6'h0, 6'h2c, 32'h3);
      xfer(1'b0, 6'h0, 6'h30, 32'h0, 32'h0, 1'b1);
      xfer(1'b0, 6'h2, 6'h00, 32'h0, 32'h0, 1'b1);
      wr_reg(6'h0, 6'h1c, 32'hffff_ffff);
      rd_reg(6'h0, 6'h1c, 32'h0);
      wr_reg(6'h0, 6'h0c, 32'hdead_beef);
      rd_reg(6'h0, 6'h0c, 32'hdead_beef);
      // Mask set and clear, interrupt line
      wr_reg(6'h0, 6'h20, 32'h7);
      rd_reg(6'h0, 6'h28, 32'h7);
      wr_reg(6'h0, 6'h24, 32'h2);
      rd_reg(6'h0, 6'h28, 32'h5);
      wr_reg(6'h0, 6'h20, 32'h0);
      wr_reg(6'h0, 6'h24, 32'h0);
      rd_reg(6'h0, 6'h28, 32'h5);
      cmp({30'h0, irq}, 32'h1);
      // Enable and disable, zeros ignored
      wr_reg(6'h0, 6'h14, 32'h1);
      rd_reg(6'h0, 6'h1c, 32'h1);
      wr_reg(6'h0, 6'h14, 32'h0);
      rd_reg(6'h0, 6'h1c, 32'h1);
      wr_reg(6'h0, 6'h14, 32'h2);
      rd_reg(6'h0, 6'h1c, 32'h0);
      wr_reg(6'h0, 6'h14, 32'h0);
      rd_reg(6'h0, 6'h1c, 32'h0);
      wr_reg(6'h0, 6'h14, 32'h1);
      // Every size code: two items, address step, counter in items
      for (int s = 0; s < 4; s++)
      begin
         step = (s == 0) ? 32'h1 : (s == 1) ? 32'h2 : 32'h4;
         prog(6'h0, 2'(s), 32'h1000, 32'h2, 32'h0, 32'h0);
         go <= 2'b01;
         wait_acks(0, 2, 32'h1000, step);
         quiet(0);
         cmp(32'(seen), 32'h0);
         go <= 2'b00;
         rd_reg(6'h0, 6'h00, 32'h1000 + 2 * step);
         rd_reg(6'h0, 6'h08, 32'h0);
         rd_reg(6'h0, 6'h18, 32'(s));
      end
      // Double buffer: reload taken in and cleared
      prog(6'h0, 2'h1, 32'h100, 32'h3, 32'h400, 32'h2);
      rd_reg(6'h0, 6'h2c, 32'h0);
      cmp({30'h0, irq}, 32'h0);
      go <= 2'b01;
      wait_acks(0, 3, 32'h100, 32'h2);
      wait_acks(0, 2, 32'h400, 32'h2);
      go <= 2'b00;
      rd_reg(6'h0, 6'h00, 32'h404);
      rd_reg(6'h0, 6'h10, 32'h0);
      rd_reg(6'h0, 6'h2c, 32'h3);
      // Fault on an invalid address, then recovery
      prog(6'h0, 2'h2, 32'hf000_0010, 32'h2, 32'h0, 32'h0);
      go <= 2'b01;
      quiet(0);
      cmp(32'(seen), 32'h0);
      rd_reg(6'h0, 6'h2c, 32'h5);
      rd_reg(6'h0, 6'h08, 32'h2);
      cmp({30'h0, irq}, 32'h1);
      wr_reg(6'h0, 6'h14, 32'h0);
      rd_reg(6'h0, 6'h2c, 32'h5);
      wr_reg(6'h0, 6'h00, 32'h200);
      wr_reg(6'h0, 6'h14, 32'h100);
      wait_acks(0, 2, 32'h200, 32'h4);
      go <= 2'b00;
      rd_reg(6'h0, 6'h2c, 32'h3);
      // Both channels at once with slow memory
      slow <= 4'h3;
      prog(6'h0, 2'h2, 32'h2000, 32'h1, 32'h0, 32'h0);
      prog(6'h1, 2'h2, 32'h3000, 32'h1, 32'h0, 32'h0);
      wr_reg(6'h1, 6'h14, 32'h1);
      go <= 2'b11;
      n = 0;
      while (pack === 2'b00 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      cmp({30'h0, pack}, 32'h1);
      wait_acks(1, 1, 32'h3000, 32'h4);
      go <= 2'b00;
      // Peripheral to memory: write request carries the word sampled at grant
      wr_reg(6'h1, 6'h18, 32'h0000_0102);
      wr_reg(6'h1, 6'h00, 32'h3100);
      wr_reg(6'h1, 6'h08, 32'h1);
      go <= 2'b10;
      n = 0;
      pword = 32'h0;
      while (mreq.req !== 1'b1 && n < 200)
      begin
         pword = pdata_in;
         @(posedge clk);
         n++;
      end
      cmp({31'h0, mreq.write}, 32'h1);
      cmp({30'h0, mreq.size}, 32'h2);
      cmp(mreq.addr, 32'h3100);
      cmp(mreq.wdata, pword);
      wait_acks(1, 1, 32'h3100, 32'h4);
      go <= 2'b00;
      finish_test();
   end
endmodule

// *** verilog/dma_pkg.sv ***
package dma_pkg;
   localparam int ADDR_W = 32;
   localparam int CNT_W = 16;
   localparam int OFS_W = 6;
   // Register offsets inside one channel window
   localparam logic [5:0] OFS_ADDR = 6'h00;
   localparam logic [5:0] OFS_PSEL = 6'h04;
   localparam logic [5:0] OFS_COUNT = 6'h08;
   localparam logic [5:0] OFS_ADDR_RELOAD = 6'h0c;
   localparam logic [5:0] OFS_COUNT_RELOAD = 6'h10;
   localparam logic [5:0] OFS_COMMAND = 6'h14;
   localparam logic [5:0] OFS_WIDTH_CFG = 6'h18;
   localparam logic [5:0] OFS_STATE = 6'h1c;
   localparam logic [5:0] OFS_MASK_SET = 6'h20;
   localparam logic [5:0] OFS_MASK_CLEAR = 6'h24;
   localparam logic [5:0] OFS_MASK_VIEW = 6'h28;
   localparam logic [5:0] OFS_FLAGS = 6'h2c;
   // Field positions
   localparam int CMD_CHANNEL_ON = 0;
   localparam int CMD_CHANNEL_OFF = 1;
   localparam int CMD_ERROR_FLAG_CLEAR = 8;
   localparam int CFG_SIZE_LSB = 0;
   localparam int CFG_DIR = 8;
   localparam int STATE_ON = 0;
   localparam int IRQ_RELOAD_EMPTY = 0;
   localparam int IRQ_ALL_DONE = 1;
   localparam int IRQ_FAULT = 2;
   localparam int IRQ_N = 3;
   // Item width codes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_MOVE = 2'b10
   } fsm_t;

   // Per channel register set
   typedef struct packed {
      logic [31:0] active_memory_address;
      logic [15:0] item_counter;
      logic [31:0] memory_address_reload;
      logic [15:0] item_count_reload;
      logic [1:0] size;
      logic dir;
      logic channel_on;
      logic transfer_fault;
      logic [2:0] irq_mask;
   } chan_t;

   // Memory bus request
   typedef struct packed {
      logic req;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0] size;
   } mem_req_t;
endpackage

// *** verilog/peripheral_dma_unit.sv ***
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module peripheral_dma_unit #(
   parameter int NUM_CH = 2,
   parameter int CH_W = 1
)
(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Memory bus master
   output dma_pkg::mem_req_t mem_out,
   input wire logic mem_ack_in,
   input wire logic mem_err_in,
   input wire logic [31:0] mem_rdata_in,
   // Peripheral handshake
   input wire logic [NUM_CH-1:0] periph_req_in,
   input wire logic [31:0] periph_data_in,
   output logic [NUM_CH-1:0] periph_ack_out,
   output logic [31:0] periph_data_out,
   // Per channel interrupt requests
   output logic [NUM_CH-1:0] irq_out
);
   typedef struct packed {
      dma_pkg::fsm_t fsm;
      logic [CH_W-1:0] act;
      dma_pkg::chan_t [NUM_CH-1:0] ch;
      dma_pkg::mem_req_t mem;
      logic [NUM_CH-1:0] ack;
      logic [31:0] pdata;
      logic [31:0] prdata;
   } state_t;

   state_t st;
   state_t next_st;
   logic [NUM_CH-1:0] eligible;
   logic [NUM_CH-1:0][2:0] flags;
   logic apb_wr;
   logic [CH_W-1:0] sel_ch;
   logic [5:0] sel_ofs;
   logic sel_hit;

   // Byte step per item for an item width code
   function automatic logic [31:0] step_bytes(input logic [1:0] size);
      if (size == dma_pkg::SIZE_BYTE)
      begin
         return 32'h0000_0001;
      end
      else if (size == dma_pkg::SIZE_HALF)
      begin
         return 32'h0000_0002;
      end
      else
      begin
         return 32'h0000_0004;
      end
   endfunction

   // Source flags of one channel
   function automatic logic [2:0] src_flags(input dma_pkg::chan_t c);
      logic [2:0] f;
      f = 3'h0;
      f[dma_pkg::IRQ_FAULT] = c.transfer_fault;
      f[dma_pkg::IRQ_ALL_DONE] = (c.item_counter == dma_pkg::CNT_ZERO) &&
         (c.item_count_reload == dma_pkg::CNT_ZERO);
      f[dma_pkg::IRQ_RELOAD_EMPTY] = (c.item_count_reload == dma_pkg::CNT_ZERO);
      return f;
   endfunction

   // Register read value; write-only and absent registers read zero
   function automatic logic [31:0] reg_read(input dma_pkg::chan_t c,
                                            input logic [5:0] ofs);
      logic [31:0] v;
      v = dma_pkg::RESET_WORD;
      if (ofs == dma_pkg::OFS_ADDR)
      begin
         v = c.active_memory_address;
      end
      else if (ofs == dma_pkg::OFS_COUNT)
      begin
         v[15:0] = c.item_counter;
      end
      else if (ofs == dma_pkg::OFS_ADDR_RELOAD)
      begin
         v = c.memory_address_reload;
      end
      else if (ofs == dma_pkg::OFS_COUNT_RELOAD)
      begin
         v[15:0] = c.item_count_reload;
      end
      else if (ofs == dma_pkg::OFS_WIDTH_CFG)
      begin
         v[dma_pkg::CFG_SIZE_LSB +: 2] = c.size;
         v[dma_pkg::CFG_DIR] = c.dir;
      end
      else if (ofs == dma_pkg::OFS_STATE)
      begin
         v[dma_pkg::STATE_ON] = c.channel_on;
      end
      else if (ofs == dma_pkg::OFS_MASK_VIEW)
      begin
         v[2:0] = c.irq_mask;
      end
      else if (ofs == dma_pkg::OFS_FLAGS)
      begin
         v[2:0] = src_flags(c);
      end
      return v;
   endfunction

   // Address decode of the channel window and register offset
   always_comb
   begin
      sel_ch = paddr_in[dma_pkg::OFS_W +: CH_W];
      sel_ofs = paddr_in[dma_pkg::OFS_W-1:0];
      sel_hit = (32'(paddr_in[11:dma_pkg::OFS_W]) < NUM_CH) &&
         (sel_ofs <= dma_pkg::OFS_FLAGS) && (sel_ofs[1:0] == 2'h0);
      apb_wr = psel_in && penable_in && pwrite_in && sel_hit;
   end

   // Flags, interrupts and service eligibility per channel
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_ch
         assign flags[gi] = src_flags(st.ch[gi]);
         assign irq_out[gi] = |(flags[gi] & st.ch[gi].irq_mask);
         // Stopped on fault or empty counter
         assign eligible[gi] = st.ch[gi].channel_on && !st.ch[gi].transfer_fault &&
            (st.ch[gi].item_counter != dma_pkg::CNT_ZERO) && periph_req_in[gi];
      end
   endgenerate

   // Next state
   always_comb
   begin
      next_st = st;
      next_st.ack = '0;
      // Reload of a drained counter; idle only, so a live item is never split
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (st.fsm == dma_pkg::S_IDLE &&
             st.ch[i].item_counter == dma_pkg::CNT_ZERO &&
             st.ch[i].item_count_reload != dma_pkg::CNT_ZERO)
         begin
            next_st.ch[i].active_memory_address = st.ch[i].memory_address_reload;
            next_st.ch[i].item_counter = st.ch[i].item_count_reload;
            next_st.ch[i].item_count_reload = dma_pkg::CNT_ZERO;
         end
      end
      // Read data captured in setup phase so it comes from a flop
      if (psel_in && !penable_in)
      begin
         next_st.prdata = sel_hit ? reg_read(st.ch[sel_ch], sel_ofs) : dma_pkg::RESET_WORD;
      end
      // Software writes
      if (apb_wr)
      begin
         if (sel_ofs == dma_pkg::OFS_ADDR)
         begin
            next_st.ch[sel_ch].active_memory_address = pwdata_in;
         end
         else if (sel_ofs == dma_pkg::OFS_COUNT)
         begin
            next_st.ch[sel_ch].item_counter = pwdata_in[15:0];
         end
         else if (sel_ofs == dma_pkg::OFS_ADDR_RELOAD)
         begin
            next_st.ch[sel_ch].memory_address_reload = pwdata_in;
         end
         else if (sel_ofs == dma_pkg::OFS_COUNT_RELOAD)
         begin
            next_st.ch[sel_ch].item_count_reload = pwdata_in[15:0];
         end
         else if (sel_ofs == dma_pkg::OFS_COMMAND)
         begin
            if (pwdata_in[dma_pkg::CMD_CHANNEL_ON])
            begin
               next_st.ch[sel_ch].channel_on = 1'b1;
            end
            if (pwdata_in[dma_pkg::CMD_CHANNEL_OFF])
            begin
               next_st.ch[sel_ch].channel_on = 1'b0;
            end
            if (pwdata_in[dma_pkg::CMD_ERROR_FLAG_CLEAR])
            begin
               next_st.ch[sel_ch].transfer_fault = 1'b0;
            end
         end
         else if (sel_ofs == dma_pkg::OFS_WIDTH_CFG)
         begin
            next_st.ch[sel_ch].size = pwdata_in[dma_pkg::CFG_SIZE_LSB +: 2];
            next_st.ch[sel_ch].dir = pwdata_in[dma_pkg::CFG_DIR];
         end
         else if (sel_ofs == dma_pkg::OFS_MASK_SET)
         begin
            next_st.ch[sel_ch].irq_mask = st.ch[sel_ch].irq_mask | pwdata_in[2:0];
         end
         else if (sel_ofs == dma_pkg::OFS_MASK_CLEAR)
         begin
            next_st.ch[sel_ch].irq_mask = st.ch[sel_ch].irq_mask & ~pwdata_in[2:0];
         end
      end
      // Transfer engine
      case (st.fsm)
         dma_pkg::S_IDLE:
         begin
            if (|eligible)
            begin
               // Lowest index wins: scan downward so it is written last
               for (int i = NUM_CH - 1; i >= 0; i--)
               begin
                  if (eligible[i])
                  begin
                     next_st.act = CH_W'(i);
                  end
               end
               next_st.fsm = dma_pkg::S_MOVE;
               next_st.mem.req = 1'b1;
               next_st.mem.write = st.ch[next_st.act].dir;
               next_st.mem.addr = st.ch[next_st.act].active_memory_address;
               next_st.mem.wdata = periph_data_in;
               next_st.mem.size = st.ch[next_st.act].size;
            end
         end
         dma_pkg::S_MOVE:
         begin
            if (mem_ack_in)
            begin
               next_st.fsm = dma_pkg::S_IDLE;
               next_st.mem.req = 1'b0;
               if (mem_err_in)
               begin
                  // Fault wins over a same-cycle clear; item stays pending
                  next_st.ch[st.act].transfer_fault = 1'b1;
               end
               else
               begin
                  next_st.ch[st.act].active_memory_address =
                     st.ch[st.act].active_memory_address +
                     step_bytes(st.ch[st.act].size);
                  next_st.ch[st.act].item_counter =
                     st.ch[st.act].item_counter - dma_pkg::CNT_ONE;
                  next_st.ack[st.act] = 1'b1;
                  next_st.pdata = mem_rdata_in;
               end
            end
         end
         default:
         begin
            next_st.fsm = dma_pkg::S_IDLE;
            next_st.mem.req = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st <= '0;
         st.fsm <= dma_pkg::S_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs; zero wait state bus, error only for unmapped words
   assign prdata_out = st.prdata;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !sel_hit;
   assign mem_out = st.mem;
   assign periph_ack_out = st.ack;
   assign periph_data_out = st.pdata;

   // Checks on channel 0; the empty-move check covers whichever channel is active
   logic ch0_apb;
   assign ch0_apb = apb_wr && (sel_ch == '0);

   sequence s_reload_due;
      st.fsm == dma_pkg::S_IDLE && st.ch[0].item_counter == dma_pkg::CNT_ZERO &&
         st.ch[0].item_count_reload != dma_pkg::CNT_ZERO && !ch0_apb;
   endsequence

   property p_reload_count;
      @(posedge core_clk_in) disable iff (rst_in)
      s_reload_due |=> st.ch[0].item_counter == $past(st.ch[0].item_count_reload) &&
         st.ch[0].item_count_reload == dma_pkg::CNT_ZERO;
   endproperty
   a_reload_count: assert property (p_reload_count)
      else $error("counter reload wrong");

   property p_reload_addr;
      @(posedge core_clk_in) disable iff (rst_in)
      s_reload_due |=> st.ch[0].active_memory_address ==
         $past(st.ch[0].memory_address_reload);
   endproperty
   a_reload_addr: assert property (p_reload_addr)
      else $error("address reload wrong");

   property p_no_empty_move;
      @(posedge core_clk_in) disable iff (rst_in)
      st.fsm == dma_pkg::S_MOVE |-> st.ch[st.act].item_counter != dma_pkg::CNT_ZERO &&
         mem_out.req;
   endproperty
   a_no_empty_move: assert property (p_no_empty_move)
      else $error("move with empty counter");

   sequence s_fault_ch0;
      st.fsm == dma_pkg::S_MOVE && st.act == '0 && mem_ack_in && mem_err_in;
   endsequence

   property p_fault_stop;
      @(posedge core_clk_in) disable iff (rst_in)
      s_fault_ch0 |=> st.ch[0].transfer_fault && st.ch[0].item_counter ==
         $past(st.ch[0].item_counter) && !periph_ack_out[0] ##1 !eligible[0];
   endproperty
   a_fault_stop: assert property (p_fault_stop)
      else $error("fault did not stop channel");

   property p_enable;
      @(posedge core_clk_in) disable iff (rst_in)
      ch0_apb && sel_ofs == dma_pkg::OFS_COMMAND && pwdata_in[1:0] == 2'h1
         |=> st.ch[0].channel_on;
   endproperty
   a_enable: assert property (p_enable)
      else $error("enable lost");

   property p_disable;
      @(posedge core_clk_in) disable iff (rst_in)
      ch0_apb && sel_ofs == dma_pkg::OFS_COMMAND && pwdata_in[1]
         |=> !st.ch[0].channel_on;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable lost");

   property p_advance;
      @(posedge core_clk_in) disable iff (rst_in)
      st.fsm == dma_pkg::S_MOVE && st.act == '0 && mem_ack_in && !mem_err_in && !ch0_apb
         |=> st.ch[0].item_counter == $past(st.ch[0].item_counter) - dma_pkg::CNT_ONE &&
         st.ch[0].active_memory_address == $past(st.ch[0].active_memory_address) +
         step_bytes($past(st.ch[0].size)) && periph_ack_out[0];
   endproperty
   a_advance: assert property (p_advance)
      else $error("item step wrong");

   property p_priority;
      @(posedge core_clk_in) disable iff (rst_in)
      st.fsm == dma_pkg::S_IDLE && eligible[0] |=> st.fsm == dma_pkg::S_MOVE &&
         st.act == '0 && mem_out.addr == $past(st.ch[0].active_memory_address);
   endproperty
   a_priority: assert property (p_priority)
      else $error("channel 0 not served first");

   property p_irq_fault;
      @(posedge core_clk_in) disable iff (rst_in)
      st.ch[0].transfer_fault && st.ch[0].irq_mask[dma_pkg::IRQ_FAULT] |-> irq_out[0];
   endproperty
   a_irq_fault: assert property (p_irq_fault)
      else $error("masked fault gives no interrupt");
endmodule
